// ### rtl/ald_datapath.sv
// Arithmetic and logic execution datapath with status flags
`timescale 1ns/100ps
`include "ald_regs.svh"

module ald_datapath #(
	parameter int DATA_W = 8
) (
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	input  wire logic               op_valid,
	input  wire ald_pkg::ald_op_t   op,
	input  wire logic [DATA_W-1:0]  dst_val,
	input  wire logic [DATA_W-1:0]  dst_hi_val,
	input  wire logic [DATA_W-1:0]  src_val,
	input  wire logic [DATA_W-1:0]  imm,
	input  wire logic               carry_in,
	output logic                    op_ready,
	output logic                    res_valid,
	output logic      [DATA_W-1:0]  result,
	output logic      [DATA_W-1:0]  result_hi,
	output logic                    flag_c,
	output logic                    flag_z,
	output logic                    flag_n,
	output logic                    flag_v,
	output logic                    flag_s,
	output logic                    flag_h
);

	// Flag logic and the word pair are built for bytes only
	if (DATA_W != 8) begin : g_width_check
		$error("ald_datapath serves an 8-bit data width only");
	end

	// Packed {h, v, c, sum}; sub selects a - b - cin, else a + b + cin
	function automatic logic [10:0] ald_addsub(input logic [7:0] a, input logic [7:0] b,
	                                           input logic cin, input logic sub);
		logic [8:0] full;
		logic [4:0] nib;
		logic       ovf;
		full = sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin}) : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
		nib  = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin})
		           : ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin});
		ovf  = sub ? ((a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]))
		           : ((a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]));
		return {nib[4], ovf, full[8], full[7:0]};
	endfunction : ald_addsub

	ald_pkg::ald_state_t state;
	logic                word_sub;
	logic                word_carry;
	logic [7:0]          word_hi_src;
	logic [`ALD_FLAG_W-1:0] flags;

	wire take     = op_valid && op_ready;
	wire in_hi    = (state == ald_pkg::st_word_hi);
	wire is_word  = (op == ald_pkg::op_word_immediate_sum) ||
	                (op == ald_pkg::op_word_immediate_difference);
	wire is_sub   = (op == ald_pkg::op_sub) || (op == ald_pkg::op_const_difference) ||
	                (op == ald_pkg::op_difference_with_borrow) ||
	                (op == ald_pkg::op_const_difference_borrow) ||
	                (op == ald_pkg::op_word_immediate_difference);
	wire use_imm  = (op == ald_pkg::op_const_difference) ||
	                (op == ald_pkg::op_const_difference_borrow) || is_word;
	wire use_cin  = (op == ald_pkg::op_add_carry) || (op == ald_pkg::op_difference_with_borrow) ||
	                (op == ald_pkg::op_const_difference_borrow);
	wire is_arith = (op <= ald_pkg::op_word_immediate_difference);

	wire [7:0]  operand_b = use_imm ? imm : src_val;
	wire [10:0] byte_res  = ald_addsub(dst_val, operand_b, use_cin & carry_in, is_sub);
	// The high byte only adds or takes the carry from the low byte
	wire [10:0] hi_res    = ald_addsub(word_hi_src, `ALD_BYTE_RESET, word_carry, word_sub);

	logic [7:0] logic_res;
	always_comb begin
		case (op)
			ald_pkg::op_and:                   logic_res = dst_val & src_val;
			ald_pkg::op_conjunction_immediate: logic_res = dst_val & imm;
			ald_pkg::op_or:                    logic_res = dst_val | src_val;
			ald_pkg::op_disjunction_immediate,
			ald_pkg::op_bit_set_mask:          logic_res = dst_val | imm;
			ald_pkg::op_exclusive_disjunction: logic_res = dst_val ^ src_val;
			ald_pkg::op_bit_clear_mask:        logic_res = dst_val & (`ALD_ALL_ONES - imm);
			ald_pkg::op_zero_minus_check:      logic_res = dst_val & dst_val;
			default:                           logic_res = `ALD_BYTE_RESET;
		endcase
	end

	wire [7:0] byte_out = is_arith ? byte_res[7:0] : logic_res;

	// Byte flags; V is forced low on logic operations
	logic [`ALD_FLAG_W-1:0] byte_flags;
	always_comb begin
		byte_flags              = `ALD_FLAGS_RESET;
		byte_flags[`ALD_FLAG_C] = byte_res[8];
		byte_flags[`ALD_FLAG_Z] = (byte_out == `ALD_BYTE_RESET);
		byte_flags[`ALD_FLAG_N] = byte_out[7];
		byte_flags[`ALD_FLAG_V] = is_arith & byte_res[9];
		byte_flags[`ALD_FLAG_H] = byte_res[10];
	end

	// Word flags come from the whole 16-bit result
	logic [`ALD_FLAG_W-1:0] word_flags;
	always_comb begin
		word_flags              = `ALD_FLAGS_RESET;
		word_flags[`ALD_FLAG_C] = hi_res[8];
		word_flags[`ALD_FLAG_Z] = (hi_res[7:0] == `ALD_BYTE_RESET) && (result == `ALD_BYTE_RESET);
		word_flags[`ALD_FLAG_N] = hi_res[7];
		word_flags[`ALD_FLAG_V] = hi_res[9];
		word_flags[`ALD_FLAG_S] = hi_res[7] ^ hi_res[9];
	end

	wire [`ALD_FLAG_W-1:0] upd_mask =
		in_hi                 ? `ALD_MASK_WORD  :
		(!take || is_word)    ? `ALD_FLAGS_RESET :
		is_arith              ? `ALD_MASK_ARITH : `ALD_MASK_LOGIC;
	wire [`ALD_FLAG_W-1:0] next_flags = in_hi ? word_flags : byte_flags;

	ald_status_reg u_status (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.upd_mask   (upd_mask),
		.next_flags (next_flags),
		.flags      (flags)
	);

	assign op_ready = !in_hi; // Word operations hold off the next request one cycle
	assign flag_c   = flags[`ALD_FLAG_C];
	assign flag_z   = flags[`ALD_FLAG_Z];
	assign flag_n   = flags[`ALD_FLAG_N];
	assign flag_v   = flags[`ALD_FLAG_V];
	assign flag_s   = flags[`ALD_FLAG_S];
	assign flag_h   = flags[`ALD_FLAG_H];

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= ald_pkg::st_idle;
		end else begin
			case (state)
				ald_pkg::st_idle:    state <= (take && is_word) ? ald_pkg::st_word_hi
				                                                : ald_pkg::st_idle;
				ald_pkg::st_word_hi: state <= ald_pkg::st_idle;
				default:             state <= ald_pkg::st_idle;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			res_valid   <= 1'b0;
			result      <= `ALD_BYTE_RESET;
			result_hi   <= `ALD_BYTE_RESET;
			word_sub    <= 1'b0;
			word_carry  <= 1'b0;
			word_hi_src <= `ALD_BYTE_RESET;
		end else begin
			res_valid <= in_hi || (take && !is_word);
			if (in_hi) begin
				result_hi <= hi_res[7:0];
			end else if (take) begin
				result      <= byte_out;
				word_sub    <= is_sub;
				word_carry  <= byte_res[8];
				word_hi_src <= dst_hi_val;
			end
		end
	end

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_word_take;
		take && is_word;
	endsequence
	sequence s_word_done;
		!op_ready ##1 (op_ready && res_valid);
	endsequence

	property p_add_one;
		take && (op == ald_pkg::op_add) |=>
			res_valid && result == 8'($past(dst_val) + $past(src_val));
	endproperty
	a_add_one: assert property (p_add_one) else $error("add result wrong");

	property p_word_two;
		s_word_take |=> s_word_done;
	endproperty
	a_word_two: assert property (p_word_two) else $error("word op not two cycles");

	property p_word_sum;
		take && (op == ald_pkg::op_word_immediate_sum) |-> ##2
			{result_hi, result} == 16'({$past(dst_hi_val, 2), $past(dst_val, 2)} + $past(imm, 2));
	endproperty
	a_word_sum: assert property (p_word_sum) else $error("word sum wrong");

	property p_sub_flags;
		take && (op == ald_pkg::op_sub) |=>
			flag_c == ($past(dst_val) < $past(src_val)) && flag_z == (result == 8'h00);
	endproperty
	a_sub_flags: assert property (p_sub_flags) else $error("sub flags wrong");

	property p_sbc_value;
		take && (op == ald_pkg::op_const_difference_borrow) |=>
			result == 8'($past(dst_val) - $past(imm) - {7'h00, $past(carry_in)});
	endproperty
	a_sbc_value: assert property (p_sbc_value) else $error("borrow sub wrong");

	property p_word_diff;
		take && (op == ald_pkg::op_word_immediate_difference) |-> ##2
			{result_hi, result} == 16'({$past(dst_hi_val, 2), $past(dst_val, 2)} - $past(imm, 2))
			&& flag_s == (flag_n ^ flag_v);
	endproperty
	a_word_diff: assert property (p_word_diff) else $error("word diff wrong");

	property p_logic_keep;
		take && !is_arith |=> !flag_v && $stable(flag_c) && $stable(flag_h) && $stable(flag_s);
	endproperty
	a_logic_keep: assert property (p_logic_keep) else $error("logic op touched flags");

	property p_clear_mask;
		take && (op == ald_pkg::op_bit_clear_mask) |=>
			result == ($past(dst_val) & ~$past(imm)) && flag_n == result[7];
	endproperty
	a_clear_mask: assert property (p_clear_mask) else $error("clear mask wrong");

	property p_test_same;
		take && (op == ald_pkg::op_zero_minus_check) |=>
			result == $past(dst_val) && flag_z == ($past(dst_val) == 8'h00);
	endproperty
	a_test_same: assert property (p_test_same) else $error("test changed value");

	property p_xor_one;
		take && (op == ald_pkg::op_exclusive_disjunction) |=>
			res_valid && result == ($past(dst_val) ^ $past(src_val));
	endproperty
	a_xor_one: assert property (p_xor_one) else $error("xor wrong");

endmodule : ald_datapath

// ### rtl/ald_status_reg.sv
// Status flag register with per-flag update mask
`timescale 1ns/100ps
`include "ald_regs.svh"

module ald_status_reg (
	input  wire logic                    core_clk,
	input  wire logic                    rst_n,
	input  wire logic [`ALD_FLAG_W-1:0]  upd_mask,
	input  wire logic [`ALD_FLAG_W-1:0]  next_flags,
	output logic      [`ALD_FLAG_W-1:0]  flags
);

	// Masked-off flags hold their old value
	wire [`ALD_FLAG_W-1:0] merged = (next_flags & upd_mask) | (flags & ~upd_mask);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flags <= `ALD_FLAGS_RESET;
		end else begin
			flags <= merged;
		end
	end

endmodule : ald_status_reg

// ### shared/ald_pkg.sv
// Operation and sequencer types of the arithmetic and logic datapath
package ald_pkg;

	typedef enum logic [3:0] {
		op_add                       = 4'h0,
		op_add_carry                 = 4'h1,
		op_word_immediate_sum        = 4'h2,
		op_sub                       = 4'h3,
		op_const_difference          = 4'h4,
		op_difference_with_borrow    = 4'h5,
		op_const_difference_borrow   = 4'h6,
		op_word_immediate_difference = 4'h7,
		op_and                       = 4'h8,
		op_conjunction_immediate     = 4'h9,
		op_or                        = 4'ha,
		op_disjunction_immediate     = 4'hb,
		op_exclusive_disjunction     = 4'hc,
		op_bit_set_mask              = 4'hd,
		op_bit_clear_mask            = 4'he,
		op_zero_minus_check          = 4'hf
	} ald_op_t;

	typedef enum logic [1:0] {
		st_idle    = 2'b00,
		st_word_hi = 2'b01
	} ald_state_t;

endpackage : ald_pkg

// ### shared/ald_regs.svh
// Flag positions, masks, reset values and cycle counts of the datapath
`ifndef ALD_REGS_SVH
`define ALD_REGS_SVH

`define ALD_FLAG_W          6
`define ALD_FLAG_C          0
`define ALD_FLAG_Z          1
`define ALD_FLAG_N          2
`define ALD_FLAG_V          3
`define ALD_FLAG_S          4
`define ALD_FLAG_H          5
`define ALD_FLAGS_RESET     6'h00
`define ALD_MASK_ARITH      6'h2f
`define ALD_MASK_WORD       6'h1f
`define ALD_MASK_LOGIC      6'h0e
`define ALD_BYTE_RESET      8'h00
`define ALD_ALL_ONES        8'hff
`define ALD_BYTE_OP_CYCLES  1
`define ALD_WORD_OP_CYCLES  2

`endif

// ### testbench/ald_datapath_tb.sv
// Self-checking bench for the arithmetic and logic datapath
`timescale 1ns/100ps
`include "ald_regs.svh"

module ald_datapath_tb;
	typedef struct {logic [7:0] hi; logic [7:0] lo; logic [5:0] f; int due;} ald_note_t;
	localparam int FC = 5, FZ = 4, FN = 3, FV = 2, FS = 1, FH = 0;
	logic              core_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              op_valid = 1'b0;
	ald_pkg::ald_op_t  op = ald_pkg::op_add;
	logic [7:0]        dst_val = 8'h00, dst_hi_val = 8'h00, src_val = 8'h00, imm = 8'h00;
	logic              carry_in = 1'b0;
	wire logic         op_ready, res_valid;
	wire logic [7:0]   result, result_hi;
	wire logic         flag_c, flag_z, flag_n, flag_v, flag_s, flag_h;
	wire logic [5:0]   obs_f = {flag_c, flag_z, flag_n, flag_v, flag_s, flag_h};
	int                seed = 32'h4b69feac;
	int                cyc = 0, bad_count = 0, comparisons = 0;
	logic [7:0]        ehi = 8'h00;
	logic [5:0]        ef = 6'h00;
	ald_note_t         notes[$];

	ald_datapath #(.DATA_W(8)) dut (.core_clk(core_clk), .rst_n(rst_n), .op_valid(op_valid),
		.op(op), .dst_val(dst_val), .dst_hi_val(dst_hi_val), .src_val(src_val), .imm(imm),
		.carry_in(carry_in), .op_ready(op_ready), .res_valid(res_valid), .result(result),
		.result_hi(result_hi), .flag_c(flag_c), .flag_z(flag_z), .flag_n(flag_n),
		.flag_v(flag_v), .flag_s(flag_s), .flag_h(flag_h));

	initial begin
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc <= cyc + 1;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	// Expected state is carried in ehi/ef because unlisted flags must hold
	function automatic ald_note_t model(ald_pkg::ald_op_t o, logic [7:0] d, dh, s, k, logic ci);
		ald_note_t n;
		logic [8:0] r9;
		logic [4:0] h5;
		logic [16:0] w;
		logic [7:0] x;
		logic cy, sb, wd;
		n.hi = ehi;
		n.f = ef;
		x = (o inside {ald_pkg::op_add, ald_pkg::op_add_carry, ald_pkg::op_sub,
			ald_pkg::op_difference_with_borrow}) ? s : k;
		cy = (o inside {ald_pkg::op_add_carry, ald_pkg::op_difference_with_borrow,
			ald_pkg::op_const_difference_borrow}) ? ci : 1'b0;
		sb = o inside {ald_pkg::op_sub, ald_pkg::op_const_difference,
			ald_pkg::op_difference_with_borrow, ald_pkg::op_const_difference_borrow,
			ald_pkg::op_word_immediate_difference};
		wd = o inside {ald_pkg::op_word_immediate_sum, ald_pkg::op_word_immediate_difference};
		if (wd) begin
			w = sb ? {1'b0, dh, d} - {9'h000, k} : {1'b0, dh, d} + {9'h000, k};
			{n.hi, n.lo} = w[15:0];
			n.f[FC] = w[16];
			n.f[FN] = w[15];
			n.f[FV] = sb ? (dh[7] & ~w[15]) : (~dh[7] & w[15]);
			n.f[FS] = n.f[FN] ^ n.f[FV];
			n.f[FZ] = (w[15:0] == 16'h0000);
		end else if (!o[3]) begin
			r9 = sb ? {1'b0, d} - {1'b0, x} - cy : {1'b0, d} + {1'b0, x} + cy;
			h5 = sb ? {1'b0, d[3:0]} - {1'b0, x[3:0]} - cy : {1'b0, d[3:0]} + {1'b0, x[3:0]} + cy;
			n.lo = r9[7:0];
			n.f[FC] = r9[8];
			n.f[FH] = h5[4];
			n.f[FN] = r9[7];
			n.f[FV] = (sb ? (d[7] ^ x[7]) : ~(d[7] ^ x[7])) & (r9[7] ^ d[7]);
			n.f[FZ] = (r9[7:0] == 8'h00);
		end else begin
			case (o)
				ald_pkg::op_and:                   n.lo = d & s;
				ald_pkg::op_conjunction_immediate: n.lo = d & k;
				ald_pkg::op_or:                    n.lo = d | s;
				ald_pkg::op_exclusive_disjunction: n.lo = d ^ s;
				ald_pkg::op_bit_clear_mask:        n.lo = d & (8'hff - k);
				ald_pkg::op_zero_minus_check:      n.lo = d & d;
				default:                           n.lo = d | k;
			endcase
			n.f[FZ] = (n.lo == 8'h00);
			n.f[FN] = n.lo[7];
			n.f[FV] = 1'b0;
		end
		// Drive lands one edge before the take, so the count runs from the edge before the take
		n.due = cyc + (wd ? `ALD_WORD_OP_CYCLES : `ALD_BYTE_OP_CYCLES);
		ehi = n.hi;
		ef = n.f;
		return n;
	endfunction : model

	// Called at a rising edge; a word op is followed by one deliberately refused request
	task automatic send(ald_pkg::ald_op_t o, logic [7:0] d, dh, s, k, logic ci);
		#1;
		op_valid = 1'b1;
		op = o;
		{dst_val, dst_hi_val, src_val, imm, carry_in} = {d, dh, s, k, ci};
		check(op_ready, 1'b1);
		notes.push_back(model(o, d, dh, s, k, ci));
		@(posedge core_clk);
		if (o inside {ald_pkg::op_word_immediate_sum, ald_pkg::op_word_immediate_difference}) begin
			#1;
			op = ald_pkg::ald_op_t'(4'($random(seed)));
			{dst_val, src_val, imm} = 24'($random(seed));
			check(op_ready, 1'b0);
			@(posedge core_clk);
		end
	endtask : send

	task automatic send_rand(ald_pkg::ald_op_t o);
		send(o, 8'($random(seed)), 8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
			1'($random(seed)));
	endtask : send_rand

	task automatic do_reset(input int n);
		#1;
		rst_n = 1'b0;
		op_valid = 1'b1;
		repeat (n) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		op_valid = 1'b0;
		ehi = 8'h00;
		ef = 6'h00;
		check({op_ready, res_valid, result, result_hi, obs_f}, {1'b1, 23'h0});
		@(posedge core_clk);
	endtask : do_reset

	task automatic idle(input int n);
		repeat (n) begin
			#1 op_valid = 1'b0;
			@(posedge core_clk);
		end
	endtask : idle

	always @(negedge core_clk) begin
		if (rst_n === 1'b1 && res_valid === 1'b1) begin
			if (notes.size() == 0) check(1, 0);
			else begin
				check(cyc, notes[0].due);
				check(result, notes[0].lo);
				check(result_hi, notes[0].hi);
				check(obs_f, notes[0].f);
				void'(notes.pop_front());
			end
		end
	end

	initial begin
		#(4 * 3000);
		bad_count++;
		end_sim();
	end

	initial begin
		do_reset(20);
		$display("test reset done");
		for (int i = 0; i < 48; i++) send_rand(ald_pkg::ald_op_t'(i[3:0]));
		idle(3);
		$display("test every operation back to back done");
		send(ald_pkg::op_add, 8'hff, 8'h00, 8'h01, 8'h00, 1'b0);
		send(ald_pkg::op_add_carry, 8'h7f, 8'h00, 8'h00, 8'h00, 1'b1);
		send(ald_pkg::op_sub, 8'h80, 8'h00, 8'h01, 8'h00, 1'b0);
		send(ald_pkg::op_const_difference_borrow, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
		send(ald_pkg::op_word_immediate_sum, 8'hff, 8'hff, 8'h00, 8'h01, 1'b0);
		send(ald_pkg::op_word_immediate_sum, 8'hff, 8'h7f, 8'h00, 8'h01, 1'b0);
		send(ald_pkg::op_word_immediate_difference, 8'h00, 8'h00, 8'h00, 8'h01, 1'b0);
		send(ald_pkg::op_word_immediate_difference, 8'h00, 8'h80, 8'h00, 8'h01, 1'b0);
		send(ald_pkg::op_bit_clear_mask, 8'hff, 8'h00, 8'h00, 8'h0f, 1'b0);
		send(ald_pkg::op_zero_minus_check, 8'h80, 8'h00, 8'h00, 8'h00, 1'b0);
		send(ald_pkg::op_zero_minus_check, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
		idle(3);
		$display("test boundary values done");
		for (int i = 0; i < 200; i++) send_rand(ald_pkg::ald_op_t'(4'($random(seed))));
		idle(3);
		$display("test random stream done");
		do_reset(2);
		send_rand(ald_pkg::op_or);
		idle(4);
		check(notes.size(), 0);
		$display("test reset in mid-run done");
		end_sim();
	end
endmodule : ald_datapath_tb
